// [hw/dvr_pkg.sv]
/*
  Package for the dynamic voltage reference register bank: register offsets,
  field positions, reset values and the carrier types of the register port.
  Assumes the serial bus slave outside decodes sub-addresses and data bytes.
*/
package dvr_pkg;

  localparam int NUM_REG = 4; // 0 buck1, 1 buck2, 2 buck3, 3 ldo2

  typedef logic [7:0] dvr_byte_t;

  // Register offsets on the serial bus
  localparam dvr_byte_t ADDR_FAULT = 8'h02;
  localparam dvr_byte_t ADDR_OUTGOOD = 8'h13;
  localparam dvr_byte_t ADDR_VCCTRL = 8'h20;
  localparam dvr_byte_t ADDR_IRQCLR = 8'h21;
  localparam dvr_byte_t ADDR_RAMP = 8'h25;
  localparam dvr_byte_t ADDR_FIRST [NUM_REG] = '{8'h23, 8'h26, 8'h29, 8'h32};
  localparam dvr_byte_t ADDR_SECOND [NUM_REG] = '{8'h24, 8'h27, 8'h2A, 8'h33};

  // Reset values
  localparam dvr_byte_t RST_TARGET = 8'h19;
  localparam dvr_byte_t RST_RAMP = 8'hFF;
  localparam dvr_byte_t RST_VCCTRL = 8'h00;
  localparam dvr_byte_t RST_RDATA = 8'h00;

  // Field positions
  localparam int CODE_MSB = 4;
  localparam int PG_MASK_BIT = 5;
  localparam int FREQ_BIT = 5;
  localparam int EDGE_MSB = 7;
  localparam int EDGE_LSB = 6;
  localparam int CODE_W = 5;
  localparam int RATE_W = 2;

  // One access from the serial bus slave
  typedef struct packed {
    logic addr_ack; // Sub-address acknowledged, one-cycle pulse
    logic wr;       // Data byte written, one-cycle pulse
    logic rd;       // Data byte requested, one-cycle pulse
    dvr_byte_t addr;
    dvr_byte_t wdata;
  } dvr_bus_req_t;

  // Drive to one reference DAC
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [RATE_W-1:0] rate;
    logic start;
  } dvr_dac_t;

endpackage

// [hw/dvr_regs.sv]
/*
  Command and status register bank for four slewing reference DACs
  (step-down regulators 1 to 3 and LDO2), the interrupt pin and power-good.
  Assumes an outside serial bus slave presents decoded accesses as one-cycle
  pulses on core_clk_in, and that each DAC reports slew completion as a pulse.
*/
`timescale 1ns/1ps

// Function
// R1: Each regulator has a select bit and a trigger bit in voltage_change_ctrl.
// R2: Select bit picks which stored 5-bit target drives the DAC input.
// R3: Setting a trigger bit starts a slew toward the selected target.
// R4: Trigger bit returns to zero by itself when the slew finishes.
// R5: Any access to interrupt_clear_reg releases the interrupt pin high.
// R6: The interrupt clears when the clear register sub-address is acknowledged.
// R7: Data written to interrupt_clear_reg is discarded, nothing else changes.
// R8: Eight target registers keep 5-bit codes in bits 4 to 0.
// R9: Select high plus trigger write uses second code; select low uses first.
// R10: Standby input high forces the second code regardless of select bits.
// R11: Host must write trigger bits after changing codes or select bits.
// R12: First-target bit 5 low pulls power-good low while that DAC slews.
// R13: Buck1 first-target bits 7:6 set the common switch edge rate.
// R14: Second-target bit 5 picks 2.25MHz when low, 1.125MHz when high.
// R15: Ramp-rate register sets each DAC slew rate independently.
// R16: Reading voltage_change_ctrl shows trigger bits high while slewing.
module dvr_regs (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire dvr_pkg::dvr_bus_req_t bus_req_in,
  input wire logic standby_select_in,
  input wire logic [dvr_pkg::NUM_REG-1:0] slew_done_in,
  input wire logic irq_event_in,
  input wire logic pg_raw_in,
  input wire logic [7:0] fault_status_in,
  input wire logic [7:0] output_good_in,
  output logic [7:0] bus_rdata_out,
  output logic irq_n_out,
  output logic power_good_out,
  output dvr_pkg::dvr_dac_t [dvr_pkg::NUM_REG-1:0] dac_out,
  output logic [1:0] edge_rate_out,
  output logic [dvr_pkg::NUM_REG-2:0] freq_sel_out
);

  localparam int N = dvr_pkg::NUM_REG;

  logic [7:0] first_q [N];
  logic [7:0] first_d [N];
  logic [7:0] second_q [N];
  logic [7:0] second_d [N];
  logic [4:0] code_q [N];
  logic [4:0] code_d [N];
  logic [N-1:0] sel_q, sel_d;
  logic [N-1:0] go_q, go_d;
  logic [N-1:0] start_q, start_d;
  logic [N-1:0] go_wr;
  logic [7:0] ramp_q, ramp_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_n_q, irq_n_d;
  logic pg_q, pg_d;
  logic wr_vcc;
  logic clr_hit;

  // Access decode; a write to the clear register matches no store.
  // The clear keys on the sub-address acknowledge, not on the data byte,
  // so the pin is already released before any data arrives.
  assign wr_vcc = bus_req_in.wr && (bus_req_in.addr == dvr_pkg::ADDR_VCCTRL);
  assign clr_hit = bus_req_in.addr_ack &&
                   (bus_req_in.addr == dvr_pkg::ADDR_IRQCLR); // R6 R7

  // Next values of targets, select and trigger bits, DAC codes
  // Standby takes priority over a trigger write, so a host cannot pull a
  // regulator off its second code while the pin holds it there.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      first_d[i] = first_q[i];
      second_d[i] = second_q[i];
      if (bus_req_in.wr && bus_req_in.addr == dvr_pkg::ADDR_FIRST[i]) begin
        first_d[i] = bus_req_in.wdata; // R8
      end
      if (bus_req_in.wr && bus_req_in.addr == dvr_pkg::ADDR_SECOND[i]) begin
        second_d[i] = bus_req_in.wdata; // R8
      end
      sel_d[i] = wr_vcc ? bus_req_in.wdata[2*i+1] : sel_q[i]; // R1
      go_wr[i] = wr_vcc && bus_req_in.wdata[2*i]; // R1
      // Set wins: a new trigger in the completing cycle is not lost
      go_d[i] = go_wr[i] || (go_q[i] && !slew_done_in[i]); // R3 R4
      start_d[i] = go_wr[i]; // R3
      code_d[i] = code_q[i];
      if (standby_select_in) begin
        code_d[i] = second_q[i][dvr_pkg::CODE_MSB:0]; // R10
      end else if (go_wr[i]) begin
        // Outside standby, new targets only reach the DAC through a trigger write
        code_d[i] = bus_req_in.wdata[2*i+1] ?
                    second_q[i][dvr_pkg::CODE_MSB:0] :
                    first_q[i][dvr_pkg::CODE_MSB:0]; // R2 R9
      end
    end
  end

  // Ramp rate, interrupt pin and power-good next values
  // Power-good uses the registered trigger bits: it drops one cycle after
  // the trigger bit rises, a small lag traded for a short decode path.
  always_comb begin
    ramp_d = ramp_q;
    if (bus_req_in.wr && bus_req_in.addr == dvr_pkg::ADDR_RAMP) begin
      ramp_d = bus_req_in.wdata; // R15
    end
    // A fresh event wins over a clear in the same cycle
    irq_n_d = irq_n_q;
    if (irq_event_in) begin
      irq_n_d = 1'b0;
    end else if (clr_hit) begin
      irq_n_d = 1'b1; // R5 R6
    end
    pg_d = pg_raw_in;
    for (int i = 0; i < N; i++) begin
      if (go_q[i] && !first_q[i][dvr_pkg::PG_MASK_BIT]) begin
        pg_d = 1'b0; // R12
      end
    end
  end

  // Read data; unmapped addresses read zero
  // The byte is registered and held until the next read, so the slave may
  // shift it out over several bit times without it moving underneath.
  always_comb begin
    rdata_d = rdata_q;
    if (bus_req_in.rd) begin
      rdata_d = 8'h00;
      case (bus_req_in.addr)
        dvr_pkg::ADDR_FAULT: rdata_d = fault_status_in;
        dvr_pkg::ADDR_OUTGOOD: rdata_d = output_good_in;
        dvr_pkg::ADDR_RAMP: rdata_d = ramp_q;
        dvr_pkg::ADDR_VCCTRL: begin
          for (int i = 0; i < N; i++) begin
            rdata_d[2*i+1] = sel_q[i];
            rdata_d[2*i] = go_q[i]; // R16
          end
        end
        default: begin
          for (int i = 0; i < N; i++) begin
            if (bus_req_in.addr == dvr_pkg::ADDR_FIRST[i]) begin
              rdata_d = first_q[i];
            end
            if (bus_req_in.addr == dvr_pkg::ADDR_SECOND[i]) begin
              rdata_d = second_q[i];
            end
          end
        end
      endcase
    end
  end

  // Register stage for all state
  // Reset is synchronous; trigger bits come up clear, so no slew starts
  // until the host writes the control register.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < N; i++) begin
        first_q[i] <= dvr_pkg::RST_TARGET;
        second_q[i] <= dvr_pkg::RST_TARGET;
        code_q[i] <= dvr_pkg::RST_TARGET[dvr_pkg::CODE_MSB:0];
      end
      sel_q <= dvr_pkg::RST_VCCTRL[N-1:0];
      go_q <= dvr_pkg::RST_VCCTRL[N-1:0];
      start_q <= dvr_pkg::RST_VCCTRL[N-1:0];
      ramp_q <= dvr_pkg::RST_RAMP;
      rdata_q <= dvr_pkg::RST_RDATA;
      irq_n_q <= 1'b1;
      pg_q <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        first_q[i] <= first_d[i];
        second_q[i] <= second_d[i];
        code_q[i] <= code_d[i];
      end
      sel_q <= sel_d;
      go_q <= go_d;
      start_q <= start_d;
      ramp_q <= ramp_d;
      rdata_q <= rdata_d;
      irq_n_q <= irq_n_d;
      pg_q <= pg_d;
    end
  end

  // Outputs taken straight from flops
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_dac
      // One concatenation per DAC keeps a single driver on each element
      assign dac_out[g] = {code_q[g], ramp_q[2*g+1:2*g], // R15
                           start_q[g]};
    end
    for (g = 0; g < N - 1; g++) begin : g_freq
      assign freq_sel_out[g] = second_q[g][dvr_pkg::FREQ_BIT]; // R14
    end
  endgenerate
  assign edge_rate_out =
    first_q[0][dvr_pkg::EDGE_MSB:dvr_pkg::EDGE_LSB]; // R13
  assign bus_rdata_out = rdata_q;
  assign irq_n_out = irq_n_q;
  assign power_good_out = pg_q;

  // Checks on the register bank
  // Access checks use decoded strobes as antecedents so they fire only on real access.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_go_sets: assert property ( // R3
    wr_vcc && bus_req_in.wdata[0] |=> go_q[0] && dac_out[0].start)
    else $error("trigger write did not start slew");
  chk_go_clears: assert property ( // R4
    go_q[1] && slew_done_in[1] && !go_wr[1] |=> !go_q[1])
    else $error("trigger bit not cleared after slew");
  chk_irq_release: assert property ( // R5 R6
    clr_hit && !irq_event_in |=> irq_n_out)
    else $error("interrupt not released on clear access");
  chk_clr_nostore: assert property ( // R7
    bus_req_in.wr && bus_req_in.addr == dvr_pkg::ADDR_IRQCLR
    |=> $stable(ramp_q) && $stable(sel_q) && $stable(first_q[0]))
    else $error("clear register write changed state");
  chk_code_second: assert property ( // R2 R9
    wr_vcc && bus_req_in.wdata[3:2] == 2'b11 && !standby_select_in
    |=> dac_out[1].code == $past(second_q[1][4:0]))
    else $error("second code not applied on trigger");
  chk_code_first: assert property ( // R9
    wr_vcc && bus_req_in.wdata[7:6] == 2'b01 && !standby_select_in
    |=> dac_out[3].code == $past(first_q[3][4:0]))
    else $error("first code not applied on trigger");
  chk_standby_code: assert property ( // R10
    standby_select_in ##1 standby_select_in
    |-> dac_out[2].code == $past(second_q[2][4:0]))
    else $error("standby did not force second code");
  chk_pg_masked: assert property ( // R12
    go_q[0] && !first_q[0][5] |=> !power_good_out)
    else $error("power-good not pulled low during slew");
  chk_read_go: assert property ( // R16
    bus_req_in.rd && bus_req_in.addr == dvr_pkg::ADDR_VCCTRL
    |=> bus_rdata_out[6] == $past(go_q[3]))
    else $error("trigger bit read back wrong");
  chk_edge_rate: assert property ( // R13
    bus_req_in.wr && bus_req_in.addr == dvr_pkg::ADDR_FIRST[0]
    |=> edge_rate_out == $past(bus_req_in.wdata[7:6]))
    else $error("edge rate not taken from write");

  // Select and trigger bookkeeping
  chk_sel_store: assert property ( // R1
    wr_vcc |=> sel_q[3] == $past(bus_req_in.wdata[7]) &&
    sel_q[0] == $past(bus_req_in.wdata[1]))
    else $error("select bits not stored on control write");
  chk_start_pulse: assert property ( // R3
    !go_wr[2] |=> !dac_out[2].start)
    else $error("slew start without trigger write");
  chk_go_holds: assert property ( // R16
    go_q[2] && !slew_done_in[2] |=> go_q[2])
    else $error("trigger bit dropped before slew end");
  chk_code_hold: assert property ( // R2
    !standby_select_in && !go_wr[0] |=> $stable(dac_out[0].code))
    else $error("code moved without trigger or standby");

  // Interrupt pin
  chk_irq_event: assert property ( // R5
    irq_event_in |=> !irq_n_out)
    else $error("interrupt event did not pull pin low");
  chk_irq_holds: assert property ( // R5
    !irq_event_in && !clr_hit |=> $stable(irq_n_out))
    else $error("interrupt pin moved without cause");

  // Target storage and read-back
  chk_target_store: assert property ( // R8
    bus_req_in.wr && bus_req_in.addr == dvr_pkg::ADDR_SECOND[3]
    |=> second_q[3] == $past(bus_req_in.wdata))
    else $error("target write not stored");
  chk_target_read: assert property ( // R8
    bus_req_in.rd && bus_req_in.addr == dvr_pkg::ADDR_FIRST[2]
    |=> bus_rdata_out == $past(first_q[2]))
    else $error("target read back wrong");
  chk_rdata_holds: assert property ( // R16
    !bus_req_in.rd |=> $stable(bus_rdata_out))
    else $error("read data changed without a read");

  // Power-good and configuration fields
  chk_pg_follows: assert property ( // R12
    !(|go_q) |=> power_good_out == $past(pg_raw_in))
    else $error("power-good does not follow raw level");
  chk_pg_unmasked: assert property ( // R12
    go_q[1] && first_q[1][dvr_pkg::PG_MASK_BIT] && !go_q[0] && !go_q[2] &&
    !go_q[3] |=> power_good_out == $past(pg_raw_in))
    else $error("masked slew still forced power-good low");
  chk_freq_sel: assert property ( // R14
    bus_req_in.wr && bus_req_in.addr == dvr_pkg::ADDR_SECOND[2]
    |=> freq_sel_out[2] == $past(bus_req_in.wdata[5]))
    else $error("frequency select not taken from write");
  chk_ramp_rate: assert property ( // R15
    bus_req_in.wr && bus_req_in.addr == dvr_pkg::ADDR_RAMP
    |=> dac_out[3].rate == $past(bus_req_in.wdata[7:6]))
    else $error("ramp rate not taken from write");

  cov_slew_done: cover property (go_q[0] ##[1:20] !go_q[0]);
  cov_irq_cycle: cover property (!irq_n_out ##[1:20] irq_n_out);
  cov_pg_low: cover property (pg_raw_in && !power_good_out && |go_q);
  cov_standby_hold: cover property (standby_select_in ##1 standby_select_in);
  cov_masked_slew: cover property (go_q[1] && first_q[1][5] && power_good_out);

endmodule // dvr_regs

// [tb/dvr_dac_model.sv]
/*
  Behavioural model of the four slewing reference DACs behind the bank.
  Assumes start pulses from the bank; each slew lasts DLY clock cycles.
*/
`timescale 1ns/1ps
module dvr_dac_model #(
  parameter int DLY = 12
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire dvr_pkg::dvr_dac_t [3:0] dac_in,
  output logic [3:0] slew_done_out
);
  int cnt [4];

  // A start reloads the slew counter; the done pulse comes at its end
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      slew_done_out[i] <= 1'b0;
      if (rst_in) cnt[i] <= 0;
      else if (dac_in[i].start) cnt[i] <= DLY;
      else if (cnt[i] == 1) begin
        cnt[i] <= 0;
        slew_done_out[i] <= 1'b1;
      end else if (cnt[i] > 1) cnt[i] <= cnt[i] - 1;
    end
  end
endmodule // dvr_dac_model

// [tb/tb_dvr_regs.sv]
/*
  Self-checking bench for the register bank, one task per scenario.
  Assumes decoded bus pulses and the DAC model on the far side.
*/
`timescale 1ns/1ps
module tb_dvr_regs;
  logic clk, rst, stby, irq_ev, pg_raw, irq_n, pg;
  dvr_pkg::dvr_bus_req_t req;
  logic [3:0] done;
  logic [7:0] rdata, fault, good, r;
  logic [7:0] fst [4];
  logic [7:0] sec [4];
  dvr_pkg::dvr_dac_t [3:0] dac;
  logic [1:0] edge_rate;
  logic [2:0] freq;
  int fail_count, comparisons;

  dvr_regs i_dut (.core_clk_in(clk), .sys_rst_in(rst), .bus_req_in(req),
    .standby_select_in(stby), .slew_done_in(done), .irq_event_in(irq_ev),
    .pg_raw_in(pg_raw), .fault_status_in(fault), .output_good_in(good),
    .bus_rdata_out(rdata), .irq_n_out(irq_n), .power_good_out(pg),
    .dac_out(dac), .edge_rate_out(edge_rate), .freq_sel_out(freq));
  dvr_dac_model i_dac (.clk_in(clk), .rst_in(rst), .dac_in(dac),
    .slew_done_out(done));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Sub-address acknowledge, then one data byte; entered 1 ns past an edge
  task automatic acc(input logic [7:0] a, d, input logic w);
    req.addr = a;
    req.wdata = d;
    req.addr_ack = 1'b1;
    @(posedge clk) #1 req.addr_ack = 1'b0;
    req.wr = w;
    req.rd = !w;
    @(posedge clk) #1 req.wr = 1'b0;
    req.rd = 1'b0;
    @(posedge clk) #1 r = rdata;
  endtask

  task automatic wr(input logic [7:0] a, d);
    acc(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, e);
    acc(a, 8'h00, 1'b0);
    chk($sformatf("reg %h", a), r, e);
  endtask

  // Bounded poll until the trigger bit of DAC i drops
  task automatic wait_idle(input int i, input logic [7:0] e);
    for (int k = 0; k < 40; k++) begin
      acc(dvr_pkg::ADDR_VCCTRL, 8'h00, 1'b0);
      if (r[2*i] === 1'b0) break;
      if (k == 39) begin
        fail_count++;
        report_and_stop;
      end
    end
    chk("ctrl idle", r, e);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      rd(dvr_pkg::ADDR_FIRST[i], dvr_pkg::RST_TARGET);
      rd(dvr_pkg::ADDR_SECOND[i], dvr_pkg::RST_TARGET);
      fst[i] = dvr_pkg::RST_TARGET;
      sec[i] = dvr_pkg::RST_TARGET;
    end
    rd(dvr_pkg::ADDR_RAMP, dvr_pkg::RST_RAMP);
    rd(dvr_pkg::ADDR_VCCTRL, dvr_pkg::RST_VCCTRL);
  endtask

  // Odd DACs select the second code, even ones the first
  task automatic t_slew;
    logic [7:0] c;
    for (int i = 0; i < 4; i++) begin
      fst[i] = 8'h02 + 8'(i);
      sec[i] = 8'h1D - 8'(i);
      wr(dvr_pkg::ADDR_FIRST[i], fst[i]);
      wr(dvr_pkg::ADDR_SECOND[i], sec[i]);
      c = (8'h01 << (2*i)) | (8'(i % 2) << (2*i+1));
      wr(dvr_pkg::ADDR_VCCTRL, c);
      chk("code", 8'(dac[i].code), ((i % 2) ? sec[i] : fst[i]) & 8'h1F);
      rd(dvr_pkg::ADDR_VCCTRL, c);
      chk("pg slewing", 8'(pg), 8'h00);
      wait_idle(i, c & ~(8'h01 << (2*i)));
      chk("pg after", 8'(pg), 8'h01);
    end
  endtask

  task automatic t_mask;
    fst[1] = fst[1] | 8'h20;
    wr(dvr_pkg::ADDR_FIRST[1], fst[1]);
    wr(dvr_pkg::ADDR_VCCTRL, 8'h04);
    rd(dvr_pkg::ADDR_VCCTRL, 8'h04);
    chk("pg masked", 8'(pg), 8'h01);
    wait_idle(1, 8'h00);
    wr(dvr_pkg::ADDR_VCCTRL, 8'h40);
    chk("code low sel", 8'(dac[3].code), fst[3] & 8'h1F);
    wait_idle(3, 8'h00);
  endtask

  // Event pulls the pin low; the acknowledge alone releases it
  task automatic t_irq;
    irq_ev = 1'b1;
    @(posedge clk) #1 irq_ev = 1'b0;
    @(posedge clk) #1 chk("irq set", 8'(irq_n), 8'h00);
    req.addr = dvr_pkg::ADDR_IRQCLR;
    req.wdata = 8'hFF;
    req.addr_ack = 1'b1;
    @(posedge clk) #1 req.addr_ack = 1'b0;
    chk("irq ack", 8'(irq_n), 8'h01);
    @(posedge clk) #1 wr(dvr_pkg::ADDR_IRQCLR, 8'hFF);
    rd(dvr_pkg::ADDR_VCCTRL, 8'h00);
    rd(dvr_pkg::ADDR_FIRST[0], fst[0]);
  endtask

  task automatic t_stby;
    stby = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++)
      chk("stby code", 8'(dac[i].code), sec[i] & 8'h1F);
    stby = 1'b0;
    pg_raw = 1'b0;
    @(posedge clk) #1 chk("pg raw", 8'(pg), 8'h00);
    pg_raw = 1'b1;
  endtask

  task automatic t_cfg;
    wr(dvr_pkg::ADDR_FIRST[0], fst[0] | 8'hC0);
    chk("edge", 8'(edge_rate), 8'h03);
    wr(dvr_pkg::ADDR_FIRST[0], fst[0] | 8'h40);
    chk("edge", 8'(edge_rate), 8'h01);
    wr(dvr_pkg::ADDR_SECOND[1], sec[1] | 8'h20);
    chk("freq", 8'(freq), 8'h02);
    wr(dvr_pkg::ADDR_RAMP, 8'h1B);
    for (int i = 0; i < 4; i++)
      chk("rate", 8'(dac[i].rate), (8'h1B >> (2*i)) & 8'h03);
  endtask

  task automatic t_status;
    rd(dvr_pkg::ADDR_FAULT, 8'hA5);
    wr(dvr_pkg::ADDR_OUTGOOD, 8'h00);
    rd(dvr_pkg::ADDR_OUTGOOD, 8'h3C);
    rd(8'h7F, 8'h00);
  endtask

  initial begin
    rst = 1'b1;
    req = '0;
    stby = 1'b0;
    irq_ev = 1'b0;
    pg_raw = 1'b1;
    fault = 8'hA5;
    good = 8'h3C;
    fail_count = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_reset;
    t_slew;
    t_mask;
    t_irq;
    t_stby;
    t_cfg;
    t_status;
    report_and_stop;
  end
endmodule // tb_dvr_regs
